//--- logic/hbcba_pkg.sv
// Package of constants and carrier types for the host configuration block
// Overview of operation
// - Collision indicator pulled low during collision
// - Link indicator pulled low while link passes
// - Transmit indicator pulled low while transmitting
// - Receive indicator pulled low while receiving
// - Power-down bit stops internal clocks
// - Buffer width bit: one 8-bit, zero 16-bit
// - System width bit: one byte, zero word
// - Two-bit size field picks 8 to 64 kbytes
// - Byte order bit picks MSB or LSB first
// - Mode straps select one of four operating modes
// - Offsets zero to seven always reach direct registers
// - Offsets eight to fifteen switch among three banks
// - Bank selection comes from register seven bits
// - Byte and word access everywhere; the data port moves a whole word either way
// - Serial timing derived from 25 MHz system clock
// - Software chooses active interrupt output pin
// - Buffer bank puts data port at offset eight
`default_nettype none
package hbcba_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned OSC_HZ = 20000000;
  localparam int unsigned SER_HZ = 10000000;
  // Serial enable period in system cycles, at least one
  localparam int unsigned SER_DIV =
    (CLK_HZ / SER_HZ) < 1 ? 1 : CLK_HZ / SER_HZ;
  localparam logic [3:0] OFF_CFG6 = 4'h6;
  localparam logic [3:0] OFF_CFG7 = 4'h7;
  localparam logic [3:0] OFF_PORT = 4'h8;
  localparam logic [3:0] OFF_IRQSEL = 4'h5;
  localparam logic [3:0] OFF_STAT = 4'h0;
  localparam int unsigned BIT_BSIZE = 0;
  localparam int unsigned BIT_BUFW = 4;
  localparam int unsigned BIT_SYSW = 5;
  localparam int unsigned BIT_ORDER = 0;
  localparam int unsigned BIT_BANK = 2;
  localparam int unsigned BIT_POWER_DOWN_BIT = 5;
  localparam logic [7:0] CFG6_RST = 8'h00;
  localparam logic [7:0] CFG7_RST = 8'h00;
  localparam logic [1:0] BANK_NODE = 2'h0;
  localparam logic [1:0] BANK_HASH = 2'h1;
  localparam logic [1:0] BANK_BUF = 2'h2;
  localparam logic [2:0] MODE_ISA_EE = 3'h0;
  localparam logic [2:0] MODE_JMP_EE = 3'h1;
  localparam logic [2:0] MODE_JMP_ID = 3'h2;
  localparam logic [2:0] MODE_GENERIC = 3'h3;
  localparam logic [31:0] WB_UNMAPPED = 32'h0000_0000;

  typedef struct packed {
    logic collision;
    logic link_pass;
    logic transmit;
    logic receive;
  } hbcba_net_t;

  typedef struct packed {
    logic collision_indicator;
    logic link_indicator;
    logic transmit_indicator;
    logic receive_indicator;
  } hbcba_led_t;

  typedef struct packed {
    logic [7:0] cfg6;
    logic [7:0] cfg7;
    logic [7:0] irqsel;
    logic [4:0][7:0] regs;
  } hbcba_unused_t;
endpackage : hbcba_pkg
`default_nettype wire

//--- logic/hbcba_top.sv
// Host configuration, bank-switched register access and indicator logic
`timescale 1ns/1ps
`default_nettype none
module hbcba_top
  import hbcba_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [1:0] wb_sel_i,
  input wire logic [15:0] wb_dat_i,
  output logic [15:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [2:0] mode_strap_i,
  input wire logic [3:0] net_status_i,
  input wire logic [15:0] port_rd_data_i,
  output logic port_rd_o,
  output logic port_wr_o,
  output logic [15:0] port_wr_data_o,
  output logic collision_indicator_o,
  output logic collision_indicator_oe_o,
  output logic link_indicator_o,
  output logic link_indicator_oe_o,
  output logic transmit_indicator_o,
  output logic transmit_indicator_oe_o,
  output logic receive_indicator_o,
  output logic receive_indicator_oe_o,
  output logic [2:0] mode_o,
  output logic sys_byte_o,
  output logic buf_byte_o,
  output logic [1:0] buf_size_o,
  output logic [16:0] buf_bytes_o,
  output logic msb_first_o,
  output logic [1:0] bank_o,
  output logic clk_run_o,
  output logic ser_en_o,
  output logic [3:0] irq_pin_sel_o
);

  typedef struct packed {
    logic [7:0] cfg6;
    logic [7:0] cfg7;
    logic [7:0] irqsel;
    logic [39:0] direct;
    logic [63:0] node;
    logic [63:0] hash;
    logic [2:0] mode;
    logic [2:0] m1;
    logic [2:0] m2;
    logic [2:0] m3;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] net;
    logic [2:0] div;
    logic ser_en;
    logic ack;
    logic [15:0] rdat;
    logic prd;
    logic pwr;
    logic [15:0] pwdat;
  } hbcba_state_t;

  hbcba_state_t st_r;
  hbcba_state_t st_nxt;

  // Merge byte lanes into an 8-bit register slice
  function automatic logic [7:0] hbcba_lane(input logic [7:0] old,
      input logic [7:0] nw, input logic en);
    hbcba_lane = en ? nw : old;
  endfunction : hbcba_lane

  // Swap halves of a word when most significant byte goes first
  function automatic logic [15:0] hbcba_order(input logic [15:0] w,
      input logic msb);
    hbcba_order = msb ? {w[7:0], w[15:8]} : w;
  endfunction : hbcba_order

  logic req;
  logic upper;
  logic [1:0] bank;
  logic [2:0] pair;
  logic [7:0] lo_q;
  logic [7:0] hi_q;
  logic [15:0] wdat;

  assign req = wb_cyc_i && wb_stb_i && !st_r.ack;
  assign upper = wb_adr_i[3];
  // Bank always read from the registered value, so a bank write only
  // steers accesses that follow it
  assign bank = st_r.cfg7[BIT_BANK +: 2];
  assign pair = {wb_adr_i[2:1], 1'b0};
  assign wdat = hbcba_order(wb_dat_i, st_r.cfg7[BIT_ORDER]);

  always_comb begin
    lo_q = 8'h00;
    hi_q = 8'h00;
    if (!upper) begin
      unique case (wb_adr_i[2:1])
        2'h0: begin
          lo_q = {4'h0, st_r.net};
          hi_q = st_r.direct[7:0];
        end
        2'h1: begin
          lo_q = st_r.direct[15:8];
          hi_q = st_r.direct[23:16];
        end
        2'h2: begin
          lo_q = st_r.direct[31:24];
          hi_q = st_r.irqsel;
        end
        default: begin
          lo_q = st_r.cfg6;
          hi_q = st_r.cfg7;
        end
      endcase
    end else begin
      unique case (bank)
        BANK_NODE: begin
          lo_q = st_r.node[8*pair +: 8];
          hi_q = st_r.node[8*pair + 8 +: 8];
        end
        BANK_HASH: begin
          lo_q = st_r.hash[8*pair +: 8];
          hi_q = st_r.hash[8*pair + 8 +: 8];
        end
        default: begin
          lo_q = 8'h00;
          hi_q = 8'h00;
        end
      endcase
    end
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = req;
    // Read data stands only in the ack cycle
    st_nxt.rdat = WB_UNMAPPED[15:0];
    st_nxt.prd = 1'b0;
    st_nxt.pwr = 1'b0;
    // Three-stage sampling of external levels
    st_nxt.s1 = net_status_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.net = st_r.s3;
    end
    st_nxt.m1 = mode_strap_i;
    st_nxt.m2 = st_r.m1;
    st_nxt.m3 = st_r.m2;
    if (st_r.m2 == st_r.m3) begin
      st_nxt.mode = st_r.m3;
    end
    // Divider runs only while clocks are enabled
    st_nxt.ser_en = 1'b0;
    if (st_r.cfg7[BIT_POWER_DOWN_BIT]) begin
      st_nxt.div = 3'h0;
    end else if (st_r.div == 3'(SER_DIV - 1)) begin
      st_nxt.div = 3'h0;
      st_nxt.ser_en = 1'b1;
    end else begin
      st_nxt.div = st_r.div + 3'h1;
    end
    if (req) begin
      st_nxt.rdat = hbcba_order({hi_q, lo_q}, st_r.cfg7[BIT_ORDER]);
      if (upper && bank == BANK_BUF && wb_adr_i[2:1] == 2'h0) begin
        st_nxt.rdat = hbcba_order(port_rd_data_i, st_r.cfg7[BIT_ORDER]);
        st_nxt.prd = !wb_we_i;
        st_nxt.pwr = wb_we_i;
        st_nxt.pwdat = wdat;
      end else if (upper && bank == BANK_BUF) begin
        st_nxt.rdat = 16'h0000;
      end
      if (wb_we_i) begin
        if (!upper) begin
          unique case (wb_adr_i[2:1])
            2'h0: st_nxt.direct[7:0] = hbcba_lane(st_r.direct[7:0],
                wdat[15:8], wb_sel_i[1]);
            2'h1: begin
              st_nxt.direct[15:8] = hbcba_lane(st_r.direct[15:8],
                  wdat[7:0], wb_sel_i[0]);
              st_nxt.direct[23:16] = hbcba_lane(st_r.direct[23:16],
                  wdat[15:8], wb_sel_i[1]);
            end
            2'h2: begin
              st_nxt.direct[31:24] = hbcba_lane(st_r.direct[31:24],
                  wdat[7:0], wb_sel_i[0]);
              st_nxt.irqsel = hbcba_lane(st_r.irqsel, wdat[15:8],
                  wb_sel_i[1]);
            end
            default: begin
              st_nxt.cfg6 = hbcba_lane(st_r.cfg6, wdat[7:0], wb_sel_i[0]);
              st_nxt.cfg7 = hbcba_lane(st_r.cfg7, wdat[15:8], wb_sel_i[1]);
            end
          endcase
        end else if (bank == BANK_NODE) begin
          st_nxt.node[8*pair +: 8] = hbcba_lane(st_r.node[8*pair +: 8],
              wdat[7:0], wb_sel_i[0]);
          st_nxt.node[8*pair + 8 +: 8] = hbcba_lane(
              st_r.node[8*pair + 8 +: 8], wdat[15:8], wb_sel_i[1]);
        end else if (bank == BANK_HASH) begin
          st_nxt.hash[8*pair +: 8] = hbcba_lane(st_r.hash[8*pair +: 8],
              wdat[7:0], wb_sel_i[0]);
          st_nxt.hash[8*pair + 8 +: 8] = hbcba_lane(
              st_r.hash[8*pair + 8 +: 8], wdat[15:8], wb_sel_i[1]);
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.cfg6 <= CFG6_RST;
      st_r.cfg7 <= CFG7_RST;
      st_r.mode <= MODE_ISA_EE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.rdat;
  assign port_rd_o = st_r.prd;
  assign port_wr_o = st_r.pwr;
  assign port_wr_data_o = st_r.pwdat;
  // Open-drain: output is low, enable active while the condition holds
  assign collision_indicator_o = 1'b0;
  assign collision_indicator_oe_o = st_r.net[3];
  assign link_indicator_o = 1'b0;
  assign link_indicator_oe_o = st_r.net[2];
  assign transmit_indicator_o = 1'b0;
  assign transmit_indicator_oe_o = st_r.net[1];
  assign receive_indicator_o = 1'b0;
  assign receive_indicator_oe_o = st_r.net[0];
  assign mode_o = st_r.mode;
  assign sys_byte_o = st_r.cfg6[BIT_SYSW];
  assign buf_byte_o = st_r.cfg6[BIT_BUFW];
  assign buf_size_o = st_r.cfg6[BIT_BSIZE +: 2];
  assign buf_bytes_o = 17'h02000 << st_r.cfg6[BIT_BSIZE +: 2];
  assign msb_first_o = st_r.cfg7[BIT_ORDER];
  assign bank_o = bank;
  assign clk_run_o = !st_r.cfg7[BIT_POWER_DOWN_BIT];
  assign ser_en_o = st_r.ser_en;
  assign irq_pin_sel_o = st_r.irqsel[3:0];

endmodule : hbcba_top
`default_nettype wire

//--- bench/hbcba_chk_sva.sv
// Checker of the host port handshake and status outputs
`timescale 1ns/1ps
`default_nettype none
module hbcba_chk
  import hbcba_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [15:0] wb_dat_o,
  input wire logic [3:0] net_status_i,
  input wire logic collision_indicator_oe_o,
  input wire logic link_indicator_oe_o,
  input wire logic transmit_indicator_oe_o,
  input wire logic receive_indicator_oe_o,
  input wire logic [2:0] mode_strap_i,
  input wire logic [2:0] mode_o,
  input wire logic [1:0] buf_size_o,
  input wire logic [16:0] buf_bytes_o,
  input wire logic clk_run_o,
  input wire logic ser_en_o,
  input wire logic port_rd_o,
  input wire logic port_wr_o,
  input wire logic [1:0] bank_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("access not answered");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack longer than one cycle");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 16'h0000; endproperty
  a_dat_idle: assert property (p_dat_idle)
    else $error("read data outside ack");
  property p_led; $stable(net_status_i)[*6] |-> {collision_indicator_oe_o,
    link_indicator_oe_o, transmit_indicator_oe_o,
    receive_indicator_oe_o} == net_status_i; endproperty
  a_led: assert property (p_led)
    else $error("indicator does not follow status");
  property p_mode; $stable(mode_strap_i)[*6] |-> mode_o == mode_strap_i;
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode does not follow straps");
  property p_size;
    buf_bytes_o == (buf_size_o == 2'h3 ? 17'h10000 :
      buf_size_o == 2'h2 ? 17'h08000 :
      buf_size_o == 2'h1 ? 17'h04000 : 17'h02000);
  endproperty
  a_size: assert property (p_size)
    else $error("buffer size mismatch");
  property p_ser; clk_run_o && ser_en_o |=> !ser_en_o; endproperty
  a_ser: assert property (p_ser)
    else $error("serial enable too long");
  property p_pwr; !clk_run_o [*2] |-> !ser_en_o; endproperty
  a_pwr: assert property (p_pwr)
    else $error("serial enable in power down");
  property p_port; port_rd_o || port_wr_o |-> wb_ack_o && bank_o == BANK_BUF;
  endproperty
  a_port: assert property (p_port)
    else $error("port strobe outside buffer bank");
endmodule : hbcba_chk
`default_nettype wire

//--- bench/hbcba_port_model.sv
// Behavioural buffer port on the far side of the register window
`timescale 1ns/1ps
`default_nettype none
module hbcba_port_model (
  input wire logic clk_i,
  input wire logic port_rd_o,
  input wire logic port_wr_o,
  input wire logic [15:0] port_wr_data_o,
  output logic [15:0] port_rd_data_i,
  output logic [15:0] last_wr_o
);
  initial port_rd_data_i = 16'h5a5a;
  // A pop shows the next word; a push is kept for the bench
  always @(posedge clk_i) begin
    if (port_rd_o) port_rd_data_i <= ~port_rd_data_i;
    if (port_wr_o) last_wr_o <= port_wr_data_o;
  end
endmodule : hbcba_port_model
`default_nettype wire

//--- bench/hbcba_top_test.sv
// Self-checking bench for the host configuration block
`timescale 1ns/1ps
`default_nettype none
module hbcba_top_test
  import hbcba_pkg::*;
;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, port_rd_o;
  logic port_wr_o, sys_byte_o, buf_byte_o, msb_first_o, clk_run_o, ser_en_o;
  logic collision_indicator_o, collision_indicator_oe_o, link_indicator_o;
  logic link_indicator_oe_o, transmit_indicator_o, transmit_indicator_oe_o;
  logic receive_indicator_o, receive_indicator_oe_o;
  logic [3:0] wb_adr_i, net_status_i, irq_pin_sel_o, oe, ind;
  logic [1:0] wb_sel_i, buf_size_o, bank_o;
  logic [2:0] mode_strap_i, mode_o;
  logic [15:0] wb_dat_i, wb_dat_o, port_rd_data_i, port_wr_data_o;
  logic [15:0] last_wr_o, rdat;
  logic [16:0] buf_bytes_o;
  int num_errors, tests_run, n;
  assign oe = {collision_indicator_oe_o, link_indicator_oe_o,
    transmit_indicator_oe_o, receive_indicator_oe_o};
  assign ind = {collision_indicator_o, link_indicator_o,
    transmit_indicator_o, receive_indicator_o};
  hbcba_top u_dut (.*);
  hbcba_port_model u_mdl (.*);
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [3:0] a,
    input logic [1:0] s, input logic [15:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <=
      {2'b11, w, a, s, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    chk(17'(wb_ack_o), 17'h1);
    rdat = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : acc
  task automatic count_ser;
    n = 0;
    repeat (10) begin
      @(posedge clk_i);
      n += int'(ser_en_o);
    end
  endtask : count_ser
  task automatic complete_run;
    $display("Errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {rst_i, net_status_i, mode_strap_i} = 8'h80;
    num_errors = 0;
    tests_run = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      mode_strap_i <= 3'(i);
      net_status_i <= 4'h1 << i;
      repeat (8) @(posedge clk_i);
      chk(17'(mode_o), 17'(i));
      chk(17'(oe[3:2]), 17'(2'((4'h1 << i) >> 2)));
      chk(17'(oe[1:0]), 17'(2'(4'h1 << i)));
      chk(17'(ind), 17'h0);
    end
    for (int i = 0; i < 4; i++) begin
      n = (i > 1) ? 3 : i; // Byte host never with word buffer
      acc(1'b1, OFF_CFG6, 2'b01, 16'(n * 16 + i));
      repeat (2) @(posedge clk_i);
      chk(17'({sys_byte_o, buf_byte_o}), 17'(n));
      chk(17'(buf_size_o), 17'(i));
      chk(buf_bytes_o, 17'h02000 << i);
    end
    acc(1'b1, OFF_IRQSEL, 2'b10, 16'h0900);
    repeat (2) @(posedge clk_i);
    chk(17'(irq_pin_sel_o), 17'h9);
    acc(1'b1, 4'h2, 2'b11, 16'h3412);
    for (int b = 0; b < 4; b++) begin
      acc(1'b1, OFF_CFG7, 2'b10, 16'(b << 10));
      acc(1'b1, OFF_PORT, 2'b11, 16'(16'hc0c0 + b));
    end
    chk(17'(last_wr_o), 17'hc0c2);
    for (int b = 0; b < 4; b++) begin
      acc(1'b1, OFF_CFG7, 2'b10, 16'(b << 10));
      acc(1'b0, OFF_PORT, 2'b11, 16'h0);
      n = b == 2 ? 'h5a5a : b == 3 ? 0 : 'hc0c0 + b;
      chk(17'(rdat), 17'(n));
      acc(1'b0, 4'h2, 2'b11, 16'h0);
      chk(17'(rdat), 17'h3412);
    end
    count_ser();
    chk(17'(n), 17'(10 / SER_DIV));
    acc(1'b1, OFF_CFG7, 2'b10, 16'h2800);
    repeat (2) @(posedge clk_i);
    count_ser();
    chk(17'({clk_run_o, 16'(n)}), 17'h0);
    acc(1'b1, OFF_CFG7, 2'b10, 16'h0900); // Buffer bank kept
    acc(1'b0, 4'h2, 2'b11, 16'h0);
    chk(17'(rdat), 17'h1234);
    chk(17'({msb_first_o, bank_o}), 17'({1'b1, BANK_BUF}));
    // The earlier port read must have popped the model's word
    acc(1'b0, OFF_PORT, 2'b11, 16'h0);
    chk(17'(rdat), 17'ha5a5);
    complete_run();
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    num_errors++;
    complete_run();
  end
endmodule : hbcba_top_test
bind hbcba_top hbcba_chk u_chk (.*);
`default_nettype wire
